// ==== verilog/servo_pulse_generator.sv ====
// Multi-channel servo pulse generator behind three core I/O registers.
// Assumes a synchronous register port from the core on the same clock.
//
// Functional notes
// - Width registers give pulse length in microseconds.
// - Update strobe loads width into selected channel.
// - Enable with update starts channel at load.
// - Disable strobe without enable stops channel.
// - Neither bit set keeps channel state unchanged.
// - Disable and update strobes always read zero.
// - Enable bit reads selected channel's enable state.
// - Channel number maps directly to pin number.
// - Many pins pulse at once, up to sixteen distinct widths.
// - Codes sixteen apart share one timer.
`timescale 1ns/1ps
module servo_pulse_generator
  import servo_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  output logic [NUM_PINS-1:0] o_servo_pin
);

  typedef enum logic [1:0] {
    FRAME_IDLE = 2'b01,
    FRAME_RUN = 2'b10
  } frame_state_e;

  reg_access_s access;
  logic [7:0] pulse_width_low;
  logic [HIGH_BITS-1:0] pulse_width_high;
  logic [CHAN_WIDTH-1:0] channel_select;
  logic [NUM_PINS-1:0] pin_enable;
  logic [4:0] tick_count;
  logic tick;
  logic [14:0] frame_count;
  logic frame_start;
  frame_state_e frame_state;
  logic control_write;
  logic enable_bit;
  logic disable_strobe;
  logic update_strobe;
  logic [CHAN_WIDTH-1:0] write_chan;
  logic [NUM_TIMERS-1:0] timer_pulse;

  // ==========================================================
  // Register access decode
  // The port is same-clock logic, so no synchroniser is used.
  assign access = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr, wdata: i_reg_wdata};
  assign control_write = access.wr && (access.addr == ADDR_CONTROL);
  assign enable_bit = access.wdata[ENABLE_POS];
  assign disable_strobe = access.wdata[DISABLE_POS];
  assign update_strobe = access.wdata[UPDATE_POS];
  assign write_chan = access.wdata[CHAN_LSB +: CHAN_WIDTH];

  // Width low byte is a plain read/write register.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pulse_width_low <= RESET_BYTE;
    end else if (access.wr && access.addr == ADDR_WIDTH_LOW) begin
      pulse_width_low <= access.wdata;
    end
  end

  // Width high register keeps only its low nibble; upper bits read zero.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pulse_width_high <= '0;
    end else if (access.wr && access.addr == ADDR_WIDTH_HIGH) begin
      pulse_width_high <= access.wdata[HIGH_BITS-1:0];
    end
  end

  // The channel field is stored; the strobes are never stored.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      channel_select <= '0;
    end else if (control_write) begin
      channel_select <= write_chan;
    end
  end

  // ==========================================================
  // Per-pin enable state
  // When enable and disable are written together, disable is ignored; enable still needs update to set.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_enable <= '0;
    end else if (control_write) begin
      if (enable_bit && update_strobe) begin
        pin_enable[write_chan] <= 1'b1;
      end else if (!enable_bit && disable_strobe) begin
        pin_enable[write_chan] <= 1'b0;
      end
      // Otherwise the enable state is left alone.
    end
  end

  // ==========================================================
  // Read data
  // Strobe positions always read zero. Reads have no side effects.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= RESET_BYTE;
    end else if (access.rd) begin
      case (access.addr)
        ADDR_CONTROL: begin
          o_reg_rdata <= {pin_enable[channel_select], 2'b00, channel_select};
        end
        ADDR_WIDTH_LOW: begin
          o_reg_rdata <= pulse_width_low;
        end
        ADDR_WIDTH_HIGH: begin
          o_reg_rdata <= {4'h0, pulse_width_high};
        end
        default: begin
          o_reg_rdata <= RESET_BYTE;
        end
      endcase
    end
  end

  // Hit flag tells the core's read mux that this block answered.
  assign o_reg_hit = access.addr == ADDR_CONTROL || access.addr == ADDR_WIDTH_LOW
    || access.addr == ADDR_WIDTH_HIGH;

  // ==========================================================
  // Microsecond tick divider
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_count <= '0;
    end else if (tick_count == TICK_LAST) begin
      tick_count <= '0;
    end else begin
      tick_count <= tick_count + 5'h01;
    end
  end

  assign tick = (tick_count == TICK_LAST);

  // ==========================================================
  // Frame sequencer
  // The first frame starts one cycle after reset so timers begin in step.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      frame_state <= FRAME_IDLE;
      frame_count <= '0;
    end else begin
      case (frame_state)
        FRAME_IDLE: begin
          frame_state <= FRAME_RUN;
          frame_count <= '0;
        end
        FRAME_RUN: begin
          if (tick) begin
            frame_count <= (frame_count == FRAME_LAST) ? 15'h0000 : frame_count + 15'h0001;
          end
        end
        default: begin
          frame_state <= FRAME_IDLE;
        end
      endcase
    end
  end

  // Frame boundary: the first frame, then each 20 ms wrap.
  assign frame_start = (frame_state == FRAME_IDLE)
    || (tick && frame_count == FRAME_LAST);

  // ==========================================================
  // Shared timers
  // Only sixteen timers exist, so codes sixteen apart share a width.
  // The later write simply overwrites the shared pending width.
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    timer_load_s load;
    assign load.load = control_write && update_strobe
      && (write_chan[3:0] == 4'(t));
    assign load.width = {pulse_width_high, pulse_width_low};

    servo_timer u_timer (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_tick(tick),
      .i_frame_start(frame_start),
      .i_load(load),
      .o_pulse(timer_pulse[t])
    );
  end

  // ==========================================================
  // Pin drive
  // Pin n is channel n; each pin is gated by its own enable.
  // Registered so pins never glitch from decode logic.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_servo_pin <= '0;
    end else begin
      for (int p = 0; p < NUM_PINS; p++) begin
        o_servo_pin[p] <= pin_enable[p] && timer_pulse[p % NUM_TIMERS];
      end
    end
  end

endmodule

// ==== include/servo_pkg.sv ====
// Package for the multi-channel servo pulse generator.
// Assumes an 8-bit I/O register port driven by the embedded core.
package servo_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CONTROL = 8'hfb;
  localparam logic [7:0] ADDR_WIDTH_LOW = 8'hfc;
  localparam logic [7:0] ADDR_WIDTH_HIGH = 8'hfd;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ==========================================================
  // Control register fields and channel, timer and width sizes
  localparam int ENABLE_POS = 7;
  localparam int DISABLE_POS = 6;
  localparam int UPDATE_POS = 5;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_WIDTH = 5;
  localparam int NUM_PINS = 32;
  localparam int NUM_TIMERS = 16;
  localparam int PULSE_BITS = 12;
  localparam int HIGH_BITS = 4;

  // ==========================================================
  // Timing
  localparam int CLOCK_HZ = 25000000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000000 * TICK_US;
  localparam int FRAME_US = 20000;
  localparam logic [14:0] FRAME_LAST = 15'(FRAME_US - 1);
  localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);

  // One register access from the core.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_s;

  // One timer's programming request.
  typedef struct packed {
    logic load;
    logic [PULSE_BITS-1:0] width;
  } timer_load_s;

endpackage

// ==== verilog/servo_timer.sv ====
// One shared pulse timer: holds a width, counts it out each frame.
// Assumes a common frame-start and microsecond-tick pulse from the top.
`timescale 1ns/1ps
module servo_timer
  import servo_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_tick,
  input wire logic i_frame_start,
  input wire timer_load_s i_load,
  output logic o_pulse
);

  logic [PULSE_BITS-1:0] pending;
  logic [PULSE_BITS-1:0] remain;

  // ==========================================================
  // Width staging
  // A new width waits in pending so a running pulse is never cut short.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pending <= '0;
    end else if (i_load.load) begin
      pending <= i_load.width;
    end
  end

  // ==========================================================
  // Pulse counter
  // The pulse is high while the microsecond countdown is nonzero.
  // The staged width is adopted only at the frame boundary.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      remain <= '0;
      o_pulse <= 1'b0;
    end else if (i_frame_start) begin
      remain <= pending;
      o_pulse <= (pending != '0);
    end else if (i_tick && remain != '0) begin
      remain <= remain - 1'b1;
      o_pulse <= (remain != 12'h001);
    end
  end

endmodule

// ==== sim/servo_assertions.sv ====
// Checker for the servo pulse generator, watching its top ports only.
// Assumes it is bound into servo_pulse_generator from the foot of this file.
`timescale 1ns/1ps
module servo_assertions
  import servo_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_hit,
  input wire logic [NUM_PINS-1:0] o_servo_pin
);
  // ==========================================================
  // Sequences
  // One clock domain, so clocking and reset are stated once.
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_wr(logic [7:0] a);
    i_reg_wr && i_reg_addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    i_reg_rd && i_reg_addr == a;
  endsequence
  sequence s_ctl(logic [2:0] b);
    i_reg_wr && i_reg_addr == ADDR_CONTROL && i_reg_wdata[7:5] == b;
  endsequence

  // ==========================================================
  // Properties
  // The bench spaces accesses three cycles apart, with two accesses between these steps.
  a_low_read_back: assert property (s_wr(ADDR_WIDTH_LOW) ##9 s_rd(ADDR_WIDTH_LOW)
    |=> o_reg_rdata == $past(i_reg_wdata, 10)) else $error("width low read back wrong");
  a_high_masked: assert property (s_rd(ADDR_WIDTH_HIGH) |=> o_reg_rdata[7:4] == 4'h0)
    else $error("width high upper bits not zero");
  a_strobes_zero: assert property (s_rd(ADDR_CONTROL) |=> o_reg_rdata[6:5] == 2'h0)
    else $error("control strobes read nonzero");
  a_enable_read: assert property (s_ctl(3'h5) ##9 s_rd(ADDR_CONTROL) |=> o_reg_rdata[7])
    else $error("enable not reported");
  a_disable_read: assert property (s_ctl(3'h2) ##9 s_rd(ADDR_CONTROL) |=> !o_reg_rdata[7])
    else $error("disable not reported");
  a_unmapped_zero: assert property (i_reg_rd && !o_reg_hit |=> o_reg_rdata == RESET_BYTE)
    else $error("unmapped read nonzero");
  a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");
  a_quiet_start: assert property ($rose(i_reset_n) |-> (o_servo_pin == '0) [*8])
    else $error("pin active after reset");
endmodule

bind servo_pulse_generator servo_assertions chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
  .o_servo_pin(o_servo_pin));

// ==== sim/servo_load.sv ====
// Servo actuator model: one load per pin, measuring time spent high.
// Assumes the pins change on the same clock that it samples on.
`timescale 1ns/1ps
module servo_load
  import servo_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [NUM_PINS-1:0] i_pin,
  output int o_len [NUM_PINS]
);
  // ==========================================================
  // Pulse measurement
  // A load only feels high time; the total over the run is one pulse per observed frame.
  initial foreach (o_len[n]) o_len[n] = 0;
  always @(posedge i_ref_clk) begin
    foreach (o_len[n]) o_len[n] += int'(i_pin[n] === 1'b1);
  end
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the servo pulse generator.
// Assumes servo_pkg, the checker and the servo load model are compiled first.
`timescale 1ns/1ps
module testbench
  import servo_pkg::*;
;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, hit;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [NUM_PINS-1:0] pin;
  int len [32], en [32], tw [16];
  int error_cnt = 0, n_checks = 0, cyc = 0, e;
  int chs [9] = '{3, 19, 5, 7, 7, 20, 20, 9, 14};
  logic [2:0] ops [9] = '{3'h5, 3'h5, 3'h4, 3'h5, 3'h2, 3'h5, 3'h1, 3'h7, 3'h3};

  // ==========================================================
  // Clock, design and load
  always #20 clk = ~clk;
  servo_pulse_generator dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_hit(hit), .o_servo_pin(pin));
  servo_load load (.i_ref_clk(clk), .i_pin(pin), .o_len(len));

  // ==========================================================
  // Tasks
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // One-cycle strobe, then a settled cycle so read data can be sampled safely.
  task automatic access(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    access(1'b0, a, 8'h00);
    chk(rdata, exp);
  endtask
  // Programs one channel with a random width; the model follows the control bits.
  task automatic prog(int ch, logic [2:0] b);
    logic [11:0] w;
    w = 12'($urandom_range(700, 1));
    access(1'b1, ADDR_WIDTH_LOW, w[7:0]);
    access(1'b1, ADDR_WIDTH_HIGH, {4'($urandom), w[11:8]});
    access(1'b1, ADDR_CONTROL, {b, 5'(ch)});
    if (b[0]) tw[ch % 16] = int'(w);
    if (b[2] && b[0]) en[ch] = 1;
    else if (!b[2] && b[1]) en[ch] = 0;
    rd_chk(ADDR_WIDTH_LOW, w[7:0]);
    rd_chk(ADDR_WIDTH_HIGH, {4'h0, w[11:8]});
    rd_chk(ADDR_CONTROL, {1'(en[ch]), 2'b00, 5'(ch)});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Timeout: one frame of 500000 cycles plus programming and pulse time.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 560000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(23));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ops[i]) rd_chk(8'hfb + 8'(i % 4), RESET_BYTE);
    chk({7'h0, hit}, 8'h01);
    $display("register test done");
    foreach (chs[i]) prog(chs[i], ops[i]);
    wait (cyc == 520000);
    foreach (len[n]) begin
      e = en[n] * tw[n % 16] * TICK_CYCLES;
      n_checks++;
      if (len[n] < e - en[n] * 25 || len[n] > e + en[n] * 25) begin
        $display("BAD %0t pin %0d high %0d exp %0d", $time, n, len[n], e);
        error_cnt++;
      end
    end
    $display("pulse test done");
    finish_test();
  end
endmodule
